// file: rtl/avg_cmp_cal_pkg.sv
// Package for the converter post-processing block: widths, encodings, structs.
// Assumes a 16-bit raw converter result and a single 20 MHz bus clock.
`default_nettype none
package avg_cmp_cal_pkg;
  localparam int unsigned RES_W = 16;
  localparam int unsigned ACC_W = 21;          // 16 bits plus log2(32)
  localparam int unsigned CNT_W = 6;
  localparam int unsigned CAL_W = 16;
  localparam int unsigned NUM_CAL = 7;         // Side results per side
  // Average count select encodings and shift amounts
  localparam logic [1:0] AVG_4 = 2'h0;
  localparam logic [1:0] AVG_8 = 2'h1;
  localparam logic [1:0] AVG_16 = 2'h2;
  localparam logic [1:0] AVG_32 = 2'h3;
  localparam logic [2:0] SHIFT_BASE = 3'h2;    // 4 conversions = shift by 2
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  // Calibration budget: converter-clock cycles plus bus cycles
  localparam int unsigned CAL_CONV_CYCLES = 14000;
  localparam int unsigned CAL_BUS_CYCLES = 100;
  localparam logic [RES_W-1:0] RES_ZERO = 16'h0000;
  localparam logic [CAL_W-1:0] CAL_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_CAL  = 2'b11
  } state_e;

  // Compare configuration travels together
  typedef struct packed {
    logic enable;
    logic greater;
    logic range;
    logic [RES_W-1:0] cv1;
    logic [RES_W-1:0] cv2;
  } cmp_cfg_s;

  // Values loaded by calibration
  typedef struct packed {
    logic [CAL_W-1:0] offset;
    logic [CAL_W-1:0] plus_sample;
    logic [CAL_W-1:0] plus_diff;
    logic [CAL_W-1:0] minus_sample;
    logic [CAL_W-1:0] minus_diff;
  } cal_vals_s;
endpackage
`default_nettype wire

// file: rtl/adc_average_compare_calibration.sv
// Averaging, automatic compare and calibration sequencing for channel A.
// Assumes an analog core that reports raw results with a one-cycle strobe on clk,
// and calibration results with a one-cycle done strobe.
// Contract
// - averaging enable averages 4, 8, 16 or 32 conversions by count select.
// - conversion active flag held through whole averaging sequence.
// - with averaging, single conversions only accumulate, no complete flag.
// - after count done and compare passes, store average, set complete flag.
// - interrupt when complete flag set and channel interrupt enable set.
// - less-than mode: true when result below first compare value.
// - greater mode: true when result at or above first compare value.
// - range with cv1<=cv2: inside inclusive or outside exclusive.
// - range with cv1>cv2: outside inclusive or inside exclusive.
// - failed compare leaves complete flag clear and result unchanged.
// - averaging plus compare compares the averaged result.
// - calibration start begins sequence only with hardware trigger select low.
// - start with hardware trigger select high sets fail, start stays clear.
// - register write or stop mode during calibration aborts and sets fail.
// - calibration end sets channel A complete flag for interrupt.
// - calibration ending with fail clear counts as success.
// - calibration loads offset and side calibration registers.
// - calibration ignores channel, continuous, compare, average, mode settings.
// - calibration may take 14000 converter cycles plus 100 bus cycles.
`timescale 1ns/1ps
`default_nettype none
module adc_average_compare_calibration (
  input wire logic clk,                                   // Bus clock, 20 MHz
  input wire logic nrst,                                  // Async reset, active low
  input wire logic clk_en,                                // Freezes all state when low
  input wire logic average_enable,                        // Hardware averaging on
  input wire logic [1:0] average_count_select,            // 4/8/16/32 conversions
  input wire avg_cmp_cal_pkg::cmp_cfg_s cmp_cfg,          // Compare setup
  input wire logic channel_a_interrupt_enable,            // Interrupt enable
  input wire logic hardware_trigger_select,               // Hardware trigger mode
  input wire logic conv_start,                            // Start pulse for a sequence
  input wire logic raw_valid,                             // Raw conversion done strobe
  input wire logic [avg_cmp_cal_pkg::RES_W-1:0] raw_data, // Raw conversion value
  input wire logic cal_start_req,                         // Software sets start bit
  input wire logic cal_stop_req,                          // Software clears start bit
  input wire logic reg_write,                             // Any other register write
  input wire logic stop_mode,                             // Stop mode entry
  input wire logic clear_complete,                        // Result read clears flag
  input wire logic cal_done,                              // Analog calibration finished
  input wire avg_cmp_cal_pkg::cal_vals_s cal_results,     // Values calibration produced
  output logic cal_run,                                   // Calibrate mode to analog core
  output logic calibration_start_bit,                     // Start bit readback
  output logic calibration_fail_flag,                     // Calibration fail
  output logic conversion_active_flag,                    // Sequence in progress
  output logic complete_flag_channel_a,                   // Conversion complete
  output logic irq,                                       // Converter interrupt
  output logic [avg_cmp_cal_pkg::RES_W-1:0] result_q,     // Result registers
  output avg_cmp_cal_pkg::cal_vals_s cal_regs_q           // Calibration registers
);

  avg_cmp_cal_pkg::state_e state_q;
  logic [avg_cmp_cal_pkg::ACC_W-1:0] acc_q;
  logic [avg_cmp_cal_pkg::CNT_W-1:0] cnt_q;
  logic [avg_cmp_cal_pkg::CNT_W-1:0] target;
  logic [2:0] shift_amt;
  logic [avg_cmp_cal_pkg::ACC_W-1:0] acc_sum;
  logic [avg_cmp_cal_pkg::RES_W-1:0] avg_value;
  logic [avg_cmp_cal_pkg::RES_W-1:0] cand;
  logic last_conv;
  logic finish;
  logic cmp_true;
  logic lt1, ge1, gt2, le2;
  logic cal_abort;
  logic cal_ok_start;
  logic cal_bad_start;
  logic set_complete;
  logic conv_pass;
  logic cal_load;
  logic in_incl_hit, out_excl_hit, out_incl_hit, in_excl_hit;

  // Number of calibration words carried by the calibration struct
  localparam int unsigned CAL_FIELDS = $bits(avg_cmp_cal_pkg::cal_vals_s) / avg_cmp_cal_pkg::CAL_W;
  logic [avg_cmp_cal_pkg::CAL_W-1:0] cal_word_q [CAL_FIELDS];

  // Timing notes for users of this block:
  // the average is truncated, never rounded, to keep the divide a plain shift;
  // compare limits are read live, so changing them mid-set alters the verdict;
  // calibration length comes from the analog core, there is no timeout here,
  // so a core that never reports done leaves the block in calibration.

  always_comb begin
    shift_amt = avg_cmp_cal_pkg::SHIFT_BASE + {1'b0, average_count_select};
    target = avg_cmp_cal_pkg::CNT_W'(avg_cmp_cal_pkg::CNT_ONE << shift_amt);
  end

  assign acc_sum = acc_q + avg_cmp_cal_pkg::ACC_W'(raw_data);
  assign avg_value = avg_cmp_cal_pkg::RES_W'(acc_sum >> shift_amt);
  assign last_conv = !average_enable || (cnt_q == target - avg_cmp_cal_pkg::CNT_ONE);
  assign cand = average_enable ? avg_value : raw_data;

  // Compare primitives
  assign lt1 = cand < cmp_cfg.cv1;
  assign ge1 = !lt1;
  assign gt2 = cand > cmp_cfg.cv2;
  assign le2 = !gt2;

  // Range outcomes; endpoints count only in the inclusive modes
  assign in_incl_hit = ge1 && le2;
  assign out_excl_hit = lt1 || gt2;
  assign out_incl_hit = ge1 || le2;
  assign in_excl_hit = lt1 && gt2;

  // Compare mode selection
  always_comb begin
    if (!cmp_cfg.range) begin
      // less than / greater or equal
      cmp_true = cmp_cfg.greater ? ge1 : lt1;
    end else if (cmp_cfg.cv1 <= cmp_cfg.cv2) begin
      cmp_true = cmp_cfg.greater ? in_incl_hit : out_excl_hit;
    end else begin
      cmp_true = cmp_cfg.greater ? out_incl_hit : in_excl_hit;
    end
  end

  // only last conversion of a set finishes
  assign finish = (state_q == avg_cmp_cal_pkg::ST_CONV) && raw_valid && last_conv;

  // Calibration start and abort decode
  // start only under software trigger
  assign cal_ok_start = cal_start_req && !hardware_trigger_select && (state_q != avg_cmp_cal_pkg::ST_CAL);
  assign cal_bad_start = cal_start_req && hardware_trigger_select;
  // write or stop aborts calibration; a second start write is a write too
  assign cal_abort = (state_q == avg_cmp_cal_pkg::ST_CAL)
                  && (reg_write || stop_mode || cal_stop_req || cal_start_req);

  // a set completes only when the compare is disabled or passes
  assign conv_pass = finish && (!cmp_cfg.enable || cmp_true);
  // clean calibration end; abort in the same cycle wins
  assign cal_load = (state_q == avg_cmp_cal_pkg::ST_CAL) && cal_done && !cal_abort;
  assign set_complete = conv_pass || cal_load;

  // Sequencer state; calibration takes priority over conversions
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= avg_cmp_cal_pkg::ST_IDLE;
    end else if (clk_en) begin
      case (state_q)
        avg_cmp_cal_pkg::ST_IDLE: begin
          if (cal_ok_start) begin
            state_q <= avg_cmp_cal_pkg::ST_CAL;
          end else if (conv_start) begin
            state_q <= avg_cmp_cal_pkg::ST_CONV;
          end
        end
        avg_cmp_cal_pkg::ST_CONV: begin
          // Any register write or stop abandons the conversion set
          if (cal_ok_start) begin
            state_q <= avg_cmp_cal_pkg::ST_CAL;
          end else if (finish || reg_write || stop_mode) begin
            state_q <= avg_cmp_cal_pkg::ST_IDLE;
          end
        end
        avg_cmp_cal_pkg::ST_CAL: begin
          // length set by analog core, no timeout here
          if (cal_abort || cal_done) begin
            state_q <= avg_cmp_cal_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= avg_cmp_cal_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Accumulator and conversion counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (state_q != avg_cmp_cal_pkg::ST_CONV || finish) begin
        acc_q <= '0;
        cnt_q <= '0;
      end else if (raw_valid) begin
        acc_q <= acc_sum;
        cnt_q <= cnt_q + avg_cmp_cal_pkg::CNT_ONE;
      end
    end
  end

  // Result register; untouched on failed compare or abort
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= avg_cmp_cal_pkg::RES_ZERO;
    end else if (clk_en) begin
      if (conv_pass) begin
        result_q <= cand;
      end
    end
  end

  // Complete flag: set wins over a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      complete_flag_channel_a <= 1'b0;
    end else if (clk_en) begin
      if (set_complete) begin
        complete_flag_channel_a <= 1'b1;
      end else if (clear_complete || conv_start) begin
        complete_flag_channel_a <= 1'b0;
      end
    end
  end

  // Calibration start bit; a refused start never sets it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calibration_start_bit <= 1'b0;
    end else if (clk_en) begin
      if (cal_ok_start) begin
        calibration_start_bit <= 1'b1;
      end else if (cal_bad_start || cal_abort || cal_load) begin
        // cleared on refusal, abort or end
        calibration_start_bit <= 1'b0;
      end
    end
  end

  // Calibration fail flag; only a fresh accepted start clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calibration_fail_flag <= 1'b0;
    end else if (clk_en) begin
      if (cal_ok_start) begin
        calibration_fail_flag <= 1'b0;
      end else if (cal_bad_start || (cal_abort && !cal_stop_req)) begin
        // abort sets fail; a plain stop does not
        calibration_fail_flag <= 1'b1;
      end
    end
  end

  // Calibration registers, one word each, loaded at successful end
  for (genvar i = 0; i < CAL_FIELDS; i++) begin : g_cal_word
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cal_word_q[i] <= avg_cmp_cal_pkg::CAL_ZERO;
      end else if (clk_en && cal_load) begin
        cal_word_q[i] <= cal_results[i*avg_cmp_cal_pkg::CAL_W +: avg_cmp_cal_pkg::CAL_W];
      end
    end
  end

  // Pack the words back into the struct in the same bit order
  always_comb begin
    cal_regs_q = '0;
    for (int j = 0; j < CAL_FIELDS; j++) begin
      cal_regs_q[j*avg_cmp_cal_pkg::CAL_W +: avg_cmp_cal_pkg::CAL_W] = cal_word_q[j];
    end
  end

  // active through whole sequence; calibration mode ignores settings
  assign conversion_active_flag = (state_q != avg_cmp_cal_pkg::ST_IDLE);
  assign cal_run = (state_q == avg_cmp_cal_pkg::ST_CAL);

  assign irq = complete_flag_channel_a && channel_a_interrupt_enable;

endmodule // adc_average_compare_calibration
`default_nettype wire

// file: testbench/acc_properties.sv
// Checker for the averaging, compare and calibration block.
// Assumes binding onto the block's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module acc_checker (
  input wire logic clk, nrst, clk_en, raw_valid, cal_done, // Clock, reset, strobes
  input wire logic channel_a_interrupt_enable, hardware_trigger_select, // Levels
  input wire logic cal_start_req, cal_stop_req, reg_write, stop_mode, // Requests
  input wire avg_cmp_cal_pkg::cal_vals_s cal_results, cal_regs_q, // Cal values
  input wire logic cal_run, calibration_start_bit, calibration_fail_flag, // Cal state
  input wire logic conversion_active_flag, complete_flag_channel_a, irq, // Status
  input wire logic [avg_cmp_cal_pkg::RES_W-1:0] result_q // Result register
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Any write or stop that aborts a running calibration and sets fail; a clean stop request is left out
  wire logic abort = reg_write || stop_mode || cal_start_req;
  sequence cal_take;
    clk_en && cal_start_req && !conversion_active_flag;
  endsequence
  sequence cal_end;
    clk_en && cal_run && cal_done && !abort && !cal_stop_req;
  endsequence
  AST_IRQ_FOLLOWS: assert property (irq == (complete_flag_channel_a && channel_a_interrupt_enable))
    else $error("irq does not follow flag and enable");
  AST_CAL_BEGIN: assert property (cal_take ##0 !hardware_trigger_select |=> calibration_start_bit && cal_run && !calibration_fail_flag)
    else $error("calibration did not start");
  AST_CAL_REFUSE: assert property (cal_take ##0 hardware_trigger_select |=> !calibration_start_bit && calibration_fail_flag && !cal_run)
    else $error("refused start not flagged");
  AST_CAL_ABORT: assert property (clk_en && cal_run && abort && !cal_done |=> !calibration_start_bit && calibration_fail_flag && !cal_run && !complete_flag_channel_a)
    else $error("calibration abort wrong");
  AST_CAL_END: assert property (cal_end |=> complete_flag_channel_a && !calibration_start_bit && !cal_run && cal_regs_q == $past(cal_results))
    else $error("calibration end wrong");
  AST_ACTIVE_FALL: assert property ($fell(conversion_active_flag) && !$past(cal_run) |-> $past(raw_valid) || $past(abort))
    else $error("active flag dropped early");
  AST_RESULT_CAUSE: assert property ($changed(result_q) |-> complete_flag_channel_a && $past(raw_valid))
    else $error("result changed without completion");
  AST_COMPLETE_CAUSE: assert property ($rose(complete_flag_channel_a) |-> $past(raw_valid) || $past(cal_done))
    else $error("complete flag set without cause");
endmodule // acc_checker
bind adc_average_compare_calibration acc_checker u_chk (.clk, .nrst, .clk_en, .raw_valid, .cal_done,
  .channel_a_interrupt_enable, .hardware_trigger_select, .cal_start_req, .cal_stop_req, .reg_write, .stop_mode,
  .cal_results, .cal_regs_q, .cal_run, .calibration_start_bit, .calibration_fail_flag, .conversion_active_flag,
  .complete_flag_channel_a, .irq, .result_q);
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for averaging, compare and calibration sequencing.
// Assumes the checker binds itself to the block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, nrst = 0, avg_en = 0, ie = 0, hts = 0, cst = 0, rv = 0, go = 0, halt = 0;
  logic wr = 0, stp = 0, clr = 0, cdone = 0, en = 1;
  logic [1:0] sel = 0;
  logic [15:0] raw = 0;
  avg_cmp_cal_pkg::cmp_cfg_s cfg = '0;
  avg_cmp_cal_pkg::cal_vals_s cres = '0;
  wire logic run, sbit, fail, act, cplt, irq;
  wire logic [15:0] res;
  wire avg_cmp_cal_pkg::cal_vals_s cregs;
  int miscompares = 0, checks_done = 0;
  adc_average_compare_calibration u_dut (.clk(clk), .nrst(nrst), .clk_en(en), .average_enable(avg_en),
    .average_count_select(sel), .cmp_cfg(cfg), .channel_a_interrupt_enable(ie), .hardware_trigger_select(hts),
    .conv_start(cst), .raw_valid(rv), .raw_data(raw), .cal_start_req(go), .cal_stop_req(halt), .reg_write(wr),
    .stop_mode(stp), .clear_complete(clr), .cal_done(cdone), .cal_results(cres), .cal_run(run),
    .calibration_start_bit(sbit), .calibration_fail_flag(fail), .conversion_active_flag(act),
    .complete_flag_channel_a(cplt), .irq(irq), .result_q(res), .cal_regs_q(cregs));
  initial forever #25 clk = ~clk;
  task automatic tick;
    @(posedge clk);
    #5;
  endtask
  task automatic chk(string n, logic [79:0] e, logic [79:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected compare outcome for one result
  function automatic logic cmp_ok(avg_cmp_cal_pkg::cmp_cfg_s c, logic [15:0] r);
    if (!c.range) return c.greater ? r >= c.cv1 : r < c.cv1;
    if (c.cv1 <= c.cv2) return c.greater ? r >= c.cv1 && r <= c.cv2 : r < c.cv1 || r > c.cv2;
    return c.greater ? r >= c.cv1 || r <= c.cv2 : r < c.cv1 && r > c.cv2;
  endfunction
  // software gain: sum, halve, set top bit
  function automatic logic [15:0] gain(logic [15:0] a, logic [15:0] b);
    logic [15:0] v;
    v = a + b;
    return {1'b1, v[15:1]};
  endfunction
  // Calibration start request with a given trigger select
  task automatic cal_try(logic t);
    hts = t;
    go = 1;
    tick;
    go = 0;
    hts = 0;
  endtask
  // One conversion set; samples hit the thresholds now and then
  task automatic conv;
    logic [20:0] sum;
    logic [15:0] av, old;
    int n;
    logic ok;
    sum = '0;
    old = res;
    n = avg_en ? 4 << sel : 1;
    cst = 1;
    tick;
    cst = 0;
    for (int i = 0; i < n; i++) begin
      raw = ($urandom % 3 == 0) ? cfg.cv1 : ($urandom % 2) ? cfg.cv2 : 16'($urandom);
      rv = 1;
      sum += 21'(raw);
      chk("active", 1, act);
      tick;
      if (i < n - 1) chk("complete", 0, cplt);
    end
    rv = 0;
    av = 16'(sum >> (avg_en ? 2 + sel : 0));
    ok = !cfg.enable || cmp_ok(cfg, av);
    chk("complete", ok, cplt);
    chk("result", ok ? av : old, res);
    chk("irq", ok && ie, irq);
    chk("active", 0, act);
    clr = 1;
    tick;
    clr = 0;
  endtask
  initial begin
    void'($urandom(32'h6687));
    repeat (10) @(posedge clk);
    #5 nrst = 1;
    tick;
    // calibrate after reset, before any conversion; setup left at defaults
    cal_try(1);
    chk("start_bit", 0, sbit);
    chk("fail", 1, fail);
    // Settings that calibration must ignore
    avg_en = 1;
    cfg.enable = 1;
    cal_try(0);
    chk("start_bit", 1, sbit);
    chk("fail", 0, fail);
    rv = 1;
    tick;
    rv = 0;
    chk("complete", 0, cplt);
    ie = 1;
    cres = 80'({$urandom, $urandom, $urandom});
    cdone = 1;
    en = 0;
    tick;
    chk("start_bit", 1, sbit);
    chk("complete", 0, cplt);
    en = 1;
    tick;
    cdone = 0;
    chk("cal_regs", cres, cregs);
    chk("gain", gain(cres.plus_sample, cres.plus_diff), gain(cregs.plus_sample, cregs.plus_diff));
    chk("complete", 1, cplt);
    chk("irq", 1, irq);
    chk("start_bit", 0, sbit);
    chk("fail", 0, fail);
    // Abort by write, by stop mode, then a clean stop
    for (int k = 0; k < 3; k++) begin
      clr = 1;
      tick;
      clr = 0;
      cal_try(0);
      wr = k == 0;
      stp = k == 1;
      halt = k == 2;
      tick;
      wr = 0;
      stp = 0;
      halt = 0;
      chk("start_bit", 0, sbit);
      chk("fail", k < 2, fail);
      chk("complete", 0, cplt);
    end
    // Random sets over all counts and compare modes
    for (int k = 0; k < 64; k++) begin
      avg_en = k[3];
      sel = k[5:4];
      ie = 1'($urandom);
      cfg = {1'(k % 5 != 0), k[1:0], 16'($urandom), 16'($urandom)};
      conv;
    end
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
